// ===== verilog/skp_pkg.sv
// Purpose: shared constants and types for the extended skip/table/xor unit
// Assumes: 8-bit data memory, 16-bit program words, AXI4-Lite register port
// Notes: all byte offsets are multiples of four
package skp_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_PTR_LOW = 8'h0c;
    localparam logic [7:0] OFS_PTR_HIGH = 8'h10;
    localparam logic [7:0] OFS_TBL_HIGH = 8'h14;

    // command word fields
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    localparam int CMD_BIT_LSB = 12;

    // status word fields
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_BAD_OP = 3;
    localparam int ST_CYC_LSB = 4;

    // reset values and fixed figures
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] LAST_PAGE_HI = 8'hff;
    localparam logic [1:0] CYC_PLAIN = 2'h2;
    localparam logic [1:0] CYC_SKIP = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // operations, in command-field order
    typedef enum logic [3:0] {
        skip_if_byte_null,
        copy_and_skip_if_null,
        skip_if_bit_null,
        table_read_specific_page,
        table_read_last_page,
        inc_then_read_specific_page,
        inc_then_read_last_page,
        exclusive_or_to_accumulator,
        exclusive_or_to_memory
    } skp_op_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_EXEC,
        ST_DUMMY
    } skp_fsm_type;

    // data memory request bundle
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } skp_dmem_req_type;

    // program memory request bundle
    typedef struct packed {
        logic rd_en;
        logic [15:0] addr;
    } skp_pmem_req_type;

    // AXI4-Lite slave bookkeeping
    typedef struct packed {
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } skp_axi_type;

endpackage

// ===== verilog/skp_exec.sv
// Purpose: executes skip tests, table reads and xor on data/program memory
// Assumes: both memories answer a read one clock after the request
// Notes: software launches one operation at a time through the command word
//
// Functional notes
// - byte-null skip reads byte, writes it back unchanged, skips on zero.
// - a taken skip adds one dummy cycle, three cycles in all.
// - copy-and-test loads byte into accumulator, skips on zero, flags kept.
// - bit test skips when selected bit is zero, flags kept.
// - specific page at high:low pointer; low byte to memory, high to latch.
// - last-page read uses last page plus low pointer; same byte split.
// - increment variant bumps low pointer, then specific-page read.
// - increment variant bumps low pointer, then last-page read.
// - xor of accumulator and byte goes to accumulator; only zero flag.
// - xor result goes back to memory; accumulator kept; only zero flag.
`timescale 1ns/1ns
module skp_exec (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // data memory
    output skp_pkg::skp_dmem_req_type dmem_req,
    input wire logic [7:0] dmem_rdata,
    // program memory
    output skp_pkg::skp_pmem_req_type pmem_req,
    input wire logic [15:0] pmem_rdata,
    // execution status
    output logic op_done,
    output logic skip_taken
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        skp_pkg::skp_fsm_type fsm;
        skp_pkg::skp_op_type op;
        logic [7:0] maddr;
        logic [2:0] bsel;
        logic [7:0] acc;
        logic zero;
        logic [7:0] ptr_low;
        logic [7:0] ptr_high;
        logic [7:0] tbl_high;
        logic skip;
        logic bad_op;
        logic [1:0] cyc;
        logic done;
        skp_pkg::skp_dmem_req_type dm;
        skp_pkg::skp_pmem_req_type pm;
        skp_pkg::skp_axi_type axi;
    } skp_state_type;

    skp_state_type s_q;
    skp_state_type s_d;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // table ops with a pre-increment of the low pointer
    function automatic logic is_inc_op(input skp_pkg::skp_op_type op);
        return op == skp_pkg::inc_then_read_specific_page ||
               op == skp_pkg::inc_then_read_last_page;
    endfunction

    // table ops that address the last program page
    function automatic logic is_last_page(input skp_pkg::skp_op_type op);
        return op == skp_pkg::table_read_last_page ||
               op == skp_pkg::inc_then_read_last_page;
    endfunction

    // any table read
    function automatic logic is_table(input skp_pkg::skp_op_type op);
        return is_last_page(op) || is_inc_op(op) ||
               op == skp_pkg::table_read_specific_page;
    endfunction

    // merge a byte lane of a write into an 8-bit register
    function automatic logic [7:0] lane0(input logic [7:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] ws);
        return ws[0] ? wd[7:0] : old;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [7:0] xr;
        logic [7:0] nptr;
        logic [3:0] opf;
        logic launch;
        xr = s_q.acc ^ dmem_rdata;
        nptr = s_q.ptr_low;
        opf = 4'h0;
        launch = 1'b0;
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.dm.rd_en = 1'b0;
        s_d.dm.wr_en = 1'b0;
        s_d.pm.rd_en = 1'b0;

        // bus: release read data and write response once taken
        if (s_q.axi.rvalid && s_axi_rready) begin
            s_d.axi.rvalid = 1'b0;
        end
        if (s_q.axi.bvalid && s_axi_bready) begin
            s_d.axi.bvalid = 1'b0;
        end

        // bus: capture address and data independently
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.axi.aw_held = 1'b1;
            s_d.axi.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.axi.w_held = 1'b1;
            s_d.axi.wdata = s_axi_wdata;
            s_d.axi.wstrb = s_axi_wstrb;
        end

        // bus: register read, answered one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.axi.rvalid = 1'b1;
            s_d.axi.rresp = skp_pkg::RESP_OKAY;
            s_d.axi.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                skp_pkg::OFS_CMD: begin
                    s_d.axi.rdata[skp_pkg::CMD_ADDR_LSB +: 8] = s_q.maddr;
                    s_d.axi.rdata[skp_pkg::CMD_OP_LSB +: 4] = s_q.op;
                    s_d.axi.rdata[skp_pkg::CMD_BIT_LSB +: 3] = s_q.bsel;
                end
                skp_pkg::OFS_STATUS: begin
                    s_d.axi.rdata[skp_pkg::ST_BUSY] =
                        s_q.fsm != skp_pkg::ST_IDLE;
                    s_d.axi.rdata[skp_pkg::ST_SKIP] = s_q.skip;
                    s_d.axi.rdata[skp_pkg::ST_ZERO] = s_q.zero;
                    s_d.axi.rdata[skp_pkg::ST_BAD_OP] = s_q.bad_op;
                    s_d.axi.rdata[skp_pkg::ST_CYC_LSB +: 2] = s_q.cyc;
                end
                skp_pkg::OFS_ACC: s_d.axi.rdata[7:0] = s_q.acc;
                skp_pkg::OFS_PTR_LOW: s_d.axi.rdata[7:0] = s_q.ptr_low;
                skp_pkg::OFS_PTR_HIGH: s_d.axi.rdata[7:0] = s_q.ptr_high;
                skp_pkg::OFS_TBL_HIGH: s_d.axi.rdata[7:0] = s_q.tbl_high;
                default: s_d.axi.rresp = skp_pkg::RESP_SLVERR;
            endcase
        end

        // bus: register write once both halves are held
        if (s_q.axi.aw_held && s_q.axi.w_held && !s_q.axi.bvalid) begin
            s_d.axi.aw_held = 1'b0;
            s_d.axi.w_held = 1'b0;
            s_d.axi.bvalid = 1'b1;
            s_d.axi.bresp = skp_pkg::RESP_OKAY;
            unique case (s_q.axi.awaddr)
                // a command needs both low lanes; ignored while busy
                skp_pkg::OFS_CMD: begin
                    launch = s_q.fsm == skp_pkg::ST_IDLE &&
                             s_q.axi.wstrb[1:0] == 2'h3;
                end
                skp_pkg::OFS_STATUS: ;
                skp_pkg::OFS_ACC: begin
                    s_d.acc = lane0(s_q.acc, s_q.axi.wdata, s_q.axi.wstrb);
                end
                skp_pkg::OFS_PTR_LOW: begin
                    s_d.ptr_low =
                        lane0(s_q.ptr_low, s_q.axi.wdata, s_q.axi.wstrb);
                end
                skp_pkg::OFS_PTR_HIGH: begin
                    s_d.ptr_high =
                        lane0(s_q.ptr_high, s_q.axi.wdata, s_q.axi.wstrb);
                end
                skp_pkg::OFS_TBL_HIGH: ;
                default: s_d.axi.bresp = skp_pkg::RESP_SLVERR;
            endcase
        end

        // execution sequence
        unique case (s_q.fsm)
            skp_pkg::ST_IDLE: begin
                opf = s_q.axi.wdata[skp_pkg::CMD_OP_LSB +: 4];
                if (launch) begin
                    if (opf > skp_pkg::exclusive_or_to_memory) begin
                        s_d.bad_op = 1'b1; // unknown code, nothing runs
                    end else begin
                        s_d.bad_op = 1'b0;
                        s_d.op = skp_pkg::skp_op_type'(opf);
                        s_d.maddr =
                            s_q.axi.wdata[skp_pkg::CMD_ADDR_LSB +: 8];
                        s_d.bsel = s_q.axi.wdata[skp_pkg::CMD_BIT_LSB +: 3];
                        s_d.skip = 1'b0;
                        s_d.fsm = skp_pkg::ST_READ;
                        if (is_inc_op(s_d.op)) begin
                            nptr = 8'(s_q.ptr_low + 8'h01);
                            s_d.ptr_low = nptr;
                        end
                        s_d.pm.rd_en = is_table(s_d.op);
                        s_d.pm.addr = is_last_page(s_d.op) ?
                            {skp_pkg::LAST_PAGE_HI, nptr} :
                            {s_q.ptr_high, nptr};
                        s_d.dm.rd_en = !is_table(s_d.op);
                        s_d.dm.addr = s_d.maddr;
                    end
                end
            end
            skp_pkg::ST_READ: begin
                // memories sample the request during this cycle
                s_d.fsm = skp_pkg::ST_EXEC;
            end
            skp_pkg::ST_EXEC: begin
                s_d.dm.addr = s_q.maddr;
                s_d.dm.wdata = dmem_rdata;
                unique case (s_q.op)
                    skp_pkg::skip_if_byte_null: begin
                        s_d.dm.wr_en = 1'b1;
                        s_d.skip = dmem_rdata == 8'h00;
                    end
                    skp_pkg::copy_and_skip_if_null: begin
                        s_d.acc = dmem_rdata;
                        s_d.skip = dmem_rdata == 8'h00;
                    end
                    skp_pkg::skip_if_bit_null: begin
                        s_d.skip = !dmem_rdata[s_q.bsel];
                    end
                    skp_pkg::exclusive_or_to_accumulator: begin
                        s_d.acc = xr;
                        s_d.zero = xr == 8'h00;
                    end
                    skp_pkg::exclusive_or_to_memory: begin
                        s_d.dm.wr_en = 1'b1;
                        s_d.dm.wdata = xr;
                        s_d.zero = xr == 8'h00;
                    end
                    default: begin
                        // all four table reads split the word alike
                        s_d.dm.wr_en = 1'b1;
                        s_d.dm.wdata = pmem_rdata[7:0];
                        s_d.tbl_high = pmem_rdata[15:8];
                    end
                endcase
                if (s_d.skip) begin
                    s_d.fsm = skp_pkg::ST_DUMMY;
                end else begin
                    s_d.fsm = skp_pkg::ST_IDLE;
                    s_d.cyc = skp_pkg::CYC_PLAIN;
                    s_d.done = 1'b1;
                end
            end
            skp_pkg::ST_DUMMY: begin
                // inserted cycle while the skipped word is fetched
                s_d.fsm = skp_pkg::ST_IDLE;
                s_d.cyc = skp_pkg::CYC_SKIP;
                s_d.done = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.fsm <= skp_pkg::ST_IDLE;
            s_q.acc <= skp_pkg::RST_BYTE;
            s_q.ptr_low <= skp_pkg::RST_BYTE;
            s_q.ptr_high <= skp_pkg::RST_BYTE;
            s_q.tbl_high <= skp_pkg::RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // ready only while the holding slot is free: no write is ever dropped
    assign s_axi_awready = !s_q.axi.aw_held;
    assign s_axi_wready = !s_q.axi.w_held;
    assign s_axi_bvalid = s_q.axi.bvalid;
    assign s_axi_bresp = s_q.axi.bresp;
    assign s_axi_arready = !s_q.axi.rvalid;
    assign s_axi_rvalid = s_q.axi.rvalid;
    assign s_axi_rdata = s_q.axi.rdata;
    assign s_axi_rresp = s_q.axi.rresp;
    assign dmem_req = s_q.dm;
    assign pmem_req = s_q.pm;
    assign op_done = s_q.done;
    assign skip_taken = s_q.skip;

endmodule // skp_exec

// ===== testbench/skp_exec_checker.sv
// Purpose: port checks for the skip/table/xor execution unit
// Assumes: command and pointer writes offer address and data together
// Notes: shadows the last command and high pointer from the bus side
`timescale 1ns/1ns
module skp_exec_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memories and status
    input wire skp_pkg::skp_dmem_req_type dmem_req,
    input wire logic [7:0] dmem_rdata,
    input wire skp_pkg::skp_pmem_req_type pmem_req,
    input wire logic [15:0] pmem_rdata,
    input wire logic op_done,
    input wire logic skip_taken
);
////////////////////////////////////////////////////////////
logic [14:0] cmd_q;
logic [7:0] phi_q;
logic [7:0] lo_q;
logic [7:0] rb_q;
logic rd_q;
logic nul_q;
logic bit_q;
wire logic [3:0] op = cmd_q[11:8];
wire logic rd = dmem_req.rd_en || pmem_req.rd_en;
wire logic hs = s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready;
// shadow state; read bytes held so late checks see the sampled data
always_ff @(posedge aclk) begin
    lo_q <= pmem_rdata[7:0];
    rb_q <= dmem_rdata;
    rd_q <= dmem_req.rd_en;
    if (!aresetn) begin
        cmd_q <= '0;
        phi_q <= '0;
        nul_q <= 1'b0;
        bit_q <= 1'b0;
    end else begin
        if (hs && s_axi_awaddr == skp_pkg::OFS_CMD) cmd_q <= s_axi_wdata[14:0];
        if (hs && s_axi_awaddr == skp_pkg::OFS_PTR_HIGH)
            phi_q <= s_axi_wdata[7:0];
        if (rd_q) nul_q <= (dmem_rdata == 8'h00);
        if (rd_q) bit_q <= dmem_rdata[cmd_q[14:12]];
    end
end
////////////////////////////////////////////////////////////
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
AST_CYCLES: assert property (
    rd |-> ##2 (op_done && !skip_taken) or ##3 (op_done && skip_taken))
    else $error("operation length or skip flag wrong");
AST_WRITE_BACK: assert property (
    rd && op == 4'h0 |-> ##2 dmem_req.wr_en && dmem_req.wdata == rb_q)
    else $error("byte not written back unchanged");
AST_NULL_SKIP: assert property (
    rd && op <= 4'h1 |-> ##3 skip_taken == nul_q)
    else $error("null skip decision wrong");
AST_BIT_SKIP: assert property (
    rd && op == 4'h2 |-> ##3 skip_taken == !bit_q)
    else $error("bit skip decision wrong");
AST_NO_WRITE: assert property (
    rd && (op == 4'h1 || op == 4'h2 || op == 4'h7)
    |-> ##1 !dmem_req.wr_en [*3])
    else $error("unexpected data memory write");
AST_PAGE: assert property (
    pmem_req.rd_en |-> pmem_req.addr[15:8] == ((op == 4'h4 || op == 4'h6)
        ? skp_pkg::LAST_PAGE_HI : phi_q))
    else $error("table page wrong");
AST_TBL_LOW: assert property (
    pmem_req.rd_en |-> ##2 dmem_req.wr_en && dmem_req.wdata == lo_q && op_done)
    else $error("table low byte not stored");
AST_WR_ADDR: assert property (
    dmem_req.wr_en |-> dmem_req.addr == cmd_q[7:0])
    else $error("write to wrong data address");
AST_DONE_PULSE: assert property (op_done |=> !op_done)
    else $error("done longer than one cycle");
AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
COV_SKIP: cover property (rd && op == 4'h0 ##3 skip_taken);
COV_TABLE: cover property (pmem_req.rd_en && op == 4'h6);
COV_XOR_MEM: cover property (rd && op == 4'h8 ##2 dmem_req.wr_en);
endmodule // skp_exec_checker

bind skp_exec skp_exec_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .pmem_req(pmem_req),
    .pmem_rdata(pmem_rdata), .op_done(op_done), .skip_taken(skip_taken)
);

// ===== testbench/skp_mem_model.sv
// Purpose: data and program memory beside the execution unit
// Assumes: reads answer one clock after the request
// Notes: program words follow a fixed pattern of their address
`timescale 1ns/1ns
module skp_mem_model (
    // clock
    input wire logic aclk,
    // memory requests and answers
    input wire skp_pkg::skp_dmem_req_type dmem_req,
    output logic [7:0] dmem_rdata,
    input wire skp_pkg::skp_pmem_req_type pmem_req,
    output logic [15:0] pmem_rdata
);
logic [7:0] mem [256];
// idle read lines toggle so stale data never looks valid
always @(posedge aclk) begin
    if (dmem_req.wr_en) mem[dmem_req.addr] <= dmem_req.wdata;
    dmem_rdata <= dmem_req.rd_en ? mem[dmem_req.addr] : ~dmem_rdata;
    pmem_rdata <= pmem_req.rd_en ? {~pmem_req.addr[7:0],
        pmem_req.addr[15:8] ^ pmem_req.addr[7:0]} : ~pmem_rdata;
end
initial dmem_rdata = 8'h00;
initial pmem_rdata = 16'h0000;
endmodule // skp_mem_model

// ===== testbench/skip_table_xor_exec_tb_top.sv
// Purpose: directed scenarios for the skip/table/xor execution unit
// Assumes: one operation at a time, launched over the register bus
// Notes: data memory is preset directly in the partner model
`timescale 1ns/1ns
module skip_table_xor_exec_tb_top;
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_done, skip_taken;
logic [7:0] s_axi_awaddr, s_axi_araddr, dmem_rdata;
logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
logic [15:0] pmem_rdata;
skp_pkg::skp_dmem_req_type dmem_req;
skp_pkg::skp_pmem_req_type pmem_req;
int failures = 0;
int tests_run = 0;
int cycles = 0;
skp_exec u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .pmem_req(pmem_req),
    .pmem_rdata(pmem_rdata), .op_done(op_done), .skip_taken(skip_taken));
skp_mem_model u_mem (.aclk(aclk), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata), .pmem_req(pmem_req), .pmem_rdata(pmem_rdata));
////////////////////////////////////////////////////////////
initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
end
// hang guard, well above the few hundred cycles needed
always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
        failures++;
        complete_run();
    end
end
task automatic complete_run();
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
        failures++;
        $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
endtask
////////////////////////////////////////////////////////////
// bus master: both write channels offered together
task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
// launch, wait for completion, then fetch the status word
task automatic do_op(input logic [3:0] op, input logic [7:0] m,
    input logic [2:0] b);
    axi_wr(skp_pkg::OFS_CMD, {17'h0, b, op, m});
    do @(posedge aclk); while (op_done !== 1'b1);
    axi_rd(skp_pkg::OFS_STATUS);
endtask
task automatic st_chk(input logic s, input logic z);
    chk(rd_d[skp_pkg::ST_SKIP], s, "skip");
    chk(rd_d[5:4], s ? 2'h3 : 2'h2, "cycles");
    chk(rd_d[skp_pkg::ST_ZERO], z, "zero flag");
    chk(rd_d[skp_pkg::ST_BUSY], 1'b0, "busy");
    chk(rd_d[skp_pkg::ST_BAD_OP], 1'b0, "bad op");
    chk(wr_r, skp_pkg::RESP_OKAY, "command response");
endtask
task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    axi_rd(a);
    chk(rd_d, {24'h0, e}, "register");
endtask
////////////////////////////////////////////////////////////
task automatic t_xor();
    axi_wr(skp_pkg::OFS_ACC, 32'h0f);
    u_mem.mem[8'h50] = 8'hf0;
    u_mem.mem[8'h51] = 8'hff;
    u_mem.mem[8'h52] = 8'h3c;
    do_op(skp_pkg::exclusive_or_to_accumulator, 8'h50, 3'h0);
    st_chk(1'b0, 1'b0);
    reg_chk(skp_pkg::OFS_ACC, 8'hff);
    do_op(skp_pkg::exclusive_or_to_accumulator, 8'h51, 3'h0);
    st_chk(1'b0, 1'b1);
    reg_chk(skp_pkg::OFS_ACC, 8'h00);
    axi_wr(skp_pkg::OFS_ACC, 32'h3c);
    do_op(skp_pkg::exclusive_or_to_memory, 8'h52, 3'h0);
    st_chk(1'b0, 1'b1);
    chk(u_mem.mem[8'h52], 8'h00, "xor to memory");
    reg_chk(skp_pkg::OFS_ACC, 8'h3c);
endtask
// zero flag stays set from the xor scenario: skip ops must not touch it
task automatic t_skip();
    u_mem.mem[8'h10] = 8'h00;
    u_mem.mem[8'h11] = 8'h80;
    do_op(skp_pkg::skip_if_byte_null, 8'h10, 3'h0);
    st_chk(1'b1, 1'b1);
    chk(u_mem.mem[8'h10], 8'h00, "byte kept");
    do_op(skp_pkg::skip_if_byte_null, 8'h11, 3'h0);
    st_chk(1'b0, 1'b1);
    chk(u_mem.mem[8'h11], 8'h80, "byte kept");
    axi_wr(skp_pkg::OFS_ACC, 32'h55);
    u_mem.mem[8'h20] = 8'h00;
    do_op(skp_pkg::copy_and_skip_if_null, 8'h20, 3'h0);
    st_chk(1'b1, 1'b1);
    reg_chk(skp_pkg::OFS_ACC, 8'h00);
    u_mem.mem[8'h21] = 8'h3c;
    do_op(skp_pkg::copy_and_skip_if_null, 8'h21, 3'h0);
    st_chk(1'b0, 1'b1);
    reg_chk(skp_pkg::OFS_ACC, 8'h3c);
endtask
task automatic t_bit();
    logic [7:0] v;
    v = 8'ha5;
    u_mem.mem[8'h30] = v;
    for (int i = 0; i < 8; i++) begin
        do_op(skp_pkg::skip_if_bit_null, 8'h30, i[2:0]);
        st_chk(~v[i], 1'b1);
    end
endtask
task automatic tbl(input logic [3:0] op, input logic [7:0] m,
    input logic [15:0] a);
    logic [15:0] w;
    w = {~a[7:0], a[15:8] ^ a[7:0]};
    do_op(op, m, 3'h0);
    st_chk(1'b0, 1'b1);
    chk(u_mem.mem[m], w[7:0], "table low byte");
    reg_chk(skp_pkg::OFS_TBL_HIGH, w[15:8]);
endtask
// low pointer set to ff before each increment so both wrap; the order
// makes every last-page read change the high latch
task automatic t_table();
    axi_wr(skp_pkg::OFS_PTR_HIGH, 32'h12);
    axi_wr(skp_pkg::OFS_PTR_LOW, 32'hff);
    tbl(skp_pkg::table_read_specific_page, 8'h40, 16'h12ff);
    tbl(skp_pkg::inc_then_read_specific_page, 8'h42, 16'h1200);
    reg_chk(skp_pkg::OFS_PTR_LOW, 8'h00);
    reg_chk(skp_pkg::OFS_PTR_HIGH, 8'h12);
    axi_wr(skp_pkg::OFS_PTR_LOW, 32'hff);
    tbl(skp_pkg::table_read_last_page, 8'h41, 16'hffff);
    tbl(skp_pkg::inc_then_read_last_page, 8'h43, 16'hff00);
    reg_chk(skp_pkg::OFS_PTR_LOW, 8'h00);
endtask
task automatic t_bus();
    reg_chk(skp_pkg::OFS_TBL_HIGH, skp_pkg::RST_BYTE);
    reg_chk(skp_pkg::OFS_ACC, skp_pkg::RST_BYTE);
    axi_rd(8'h20);
    chk(rd_r, skp_pkg::RESP_SLVERR, "unmapped response");
    chk(rd_d, 32'h0, "unmapped data");
    axi_wr(8'h20, 32'h0);
    chk(wr_r, skp_pkg::RESP_SLVERR, "unmapped write response");
    // illegal op code: flagged, nothing runs
    axi_wr(skp_pkg::OFS_CMD, 32'h0000_0f00);
    axi_rd(skp_pkg::OFS_STATUS);
    chk(rd_d[skp_pkg::ST_BAD_OP], 1'b1, "illegal op flag");
    chk(rd_d[skp_pkg::ST_BUSY], 1'b0, "illegal op started");
endtask
////////////////////////////////////////////////////////////
initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_xor();
    t_skip();
    t_bit();
    t_table();
    complete_run();
end
endmodule // skip_table_xor_exec_tb_top
